//--- rtl/fq_host.sv
// Summary of operation
// [R01] three unlock writes enter secure region
// [R02] four writes exit secure region to array
// [R03] secure mode allows reads and customer programming
// [R04] secure data appears at first_array_sector addresses
// [R05] secure mode held until exit command
// [R06] query 98h at 55h word, AAh byte
// [R07] word-mode query reads keep bits 22..7 zero
// [R08] reset leaves query entered from array
// [R09] query also accepted from identification mode
// [R10] reset from such query returns to identification
// [R11] words 10h-12h read 0051h 0052h 0059h
// [R12] words 13h,14h read 0002h,0000h
// [R13] words 15h,16h read 0040h,0000h
// [R14] words 17h-1Ah read zero
// [R15] words 1Bh,1Ch read 0027h,0036h
// [R16] words 1Dh,1Eh read zero
// [R17] typical timeouts 0003h,0004h,0009h,0000h
// [R18] maximum timeouts 0005h,0005h,0004h,0000h
// [R19] size 0018h, interface 0002h,0000h
// [R20] words 2Ah,2Bh read 0006h,0000h
// [R21] word 2Ch reads 0001h
// [R22] region one 007Fh,0,0,0002h; rest zero
// [R23] power-up or reset returns to array
// [R24] byte mode: doubled address, low byte
`timescale 1ns/1ps
module fq_host
  import fq_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_byte_mode,
  input  wire logic        i_req_valid,
  input  wire fq_req_t     i_req,
  output logic             o_ready,
  output logic             o_done,
  output logic             o_err,
  output logic             o_mismatch,
  output logic      [15:0] o_rdata,
  output fq_mode_t         o_mode,
  output logic      [22:0] o_addr,
  output logic      [15:0] o_dq_out,
  output logic      [15:0] o_dq_oe,
  input  wire logic [15:0] i_dq_in,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n
);

  ////////////////////////////////////////////////////////////////////////////
  // command sequences as bus cycles
  function automatic fq_cyc_t cyc_of(input fq_op_t op, input logic [2:0] step,
                                     input logic bm, input logic [23:0] ua,
                                     input logic [15:0] ud);
    fq_cyc_t c;
    logic [23:0] u1;
    logic [23:0] u2;
    u1 = bm ? UNL1_B : UNL1_W;
    u2 = bm ? UNL2_B : UNL2_W;
    c  = '{last: 1'b1, rd: 1'b0, ext: ZERO_A, data: '0};
    case (op)
      OP_READ:   c = '{last: 1'b1, rd: 1'b1, ext: ua, data: '0};  // see [R04]
      OP_WRITE:  c = '{last: 1'b1, rd: 1'b0, ext: ua, data: ud};  // see [R03]
      OP_QCHECK: c = '{last: 1'b1, rd: 1'b1,
                       ext: bm ? {ua[22:0], 1'b0} : ua, data: '0};  // see [R24]
      OP_QUERY:  c = '{last: 1'b1, rd: 1'b0, ext: bm ? QRY_B : QRY_W,
                       data: D_QRY};  // see [R06]
      OP_RESET:  c = '{last: 1'b1, rd: 1'b0, ext: ZERO_A, data: D_RST};
      OP_SEC_ENTER, OP_SEC_EXIT, OP_AUTOSEL: begin
        case (step)
          3'd0:    c = '{last: 1'b0, rd: 1'b0, ext: u1, data: D_UNL1};
          3'd1:    c = '{last: 1'b0, rd: 1'b0, ext: u2, data: D_UNL2};
          3'd2:    c = '{last: op != OP_SEC_EXIT, rd: 1'b0, ext: u1,
                         data: (op == OP_SEC_ENTER) ? D_SEC : D_ID};  // see [R01]
          default: c = '{last: 1'b1, rd: 1'b0, ext: ZERO_A, data: D_EXIT0};  // see [R02]
        endcase
      end
      default:   c = '{last: 1'b1, rd: 1'b0, ext: ZERO_A, data: '0};
    endcase
    return c;
  endfunction

  function automatic fq_mode_t mode_after(input fq_op_t op, input fq_mode_t m);
    fq_mode_t r;
    r = m;
    case (op)
      OP_SEC_ENTER: r = M_SECURE;  // see [R01]
      OP_SEC_EXIT:  r = M_ARRAY;   // see [R02]
      OP_AUTOSEL:   r = (m == M_SECURE) ? m : M_IDENT;
      OP_QUERY:     r = (m == M_IDENT) ? M_QRY_ID : M_QRY_ARR;  // see [R09]
      // secure mode ignores the reset command; only exit leaves it
      OP_RESET:     r = (m == M_QRY_ID) ? M_IDENT :
                        (m == M_SECURE) ? M_SECURE : M_ARRAY;  // see [R05] [R08] [R10]
      default:      r = m;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  fq_state_t   s_r;
  fq_state_t   s_nxt;
  fq_cyc_t     cyc;
  logic [15:0] exp_word;
  logic [15:0] rd_val;

  fq_rom u_rom (
    .i_ref_clk (i_ref_clk),
    .i_widx    (s_r.uaddr[5:0]),
    .o_word    (exp_word)
  );

  always_comb begin
    cyc    = cyc_of(s_r.op, s_r.step, i_byte_mode, s_r.uaddr, s_r.udata);
    rd_val = i_byte_mode ? (s_r.dq_s2 & ~HI_BYTE) : s_r.dq_s2;  // see [R24]
    s_nxt       = s_r;
    s_nxt.dq_s1 = i_dq_in;
    s_nxt.dq_s2 = s_r.dq_s1;
    s_nxt.done  = 1'b0;
    s_nxt.err   = 1'b0;
    case (s_r.ph)
      PH_IDLE: begin
        if (i_req_valid && s_r.ready) begin
          s_nxt.op    = i_req.op;
          s_nxt.uaddr = i_req.addr;
          s_nxt.udata = i_req.data;
          s_nxt.step  = '0;
          // query only from array read or identification
          if (i_req.op == OP_QUERY && !(s_r.mode == M_ARRAY || s_r.mode == M_IDENT)) begin
            s_nxt.err  = 1'b1;  // see [R06] [R09]
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.ready = 1'b0;
            s_nxt.ph    = PH_ISSUE;
          end
        end
      end
      PH_ISSUE: begin
        s_nxt.rd    = cyc.rd;
        s_nxt.last  = cyc.last;
        s_nxt.ce_n  = 1'b0;
        s_nxt.addr  = i_byte_mode ? cyc.ext[23:1] : cyc.ext[22:0];
        if (!i_byte_mode && cyc.rd && (s_r.mode == M_QRY_ARR || s_r.mode == M_QRY_ID)) begin
          s_nxt.addr[QA_MSB:QA_LSB] = '0;  // see [R07]
        end
        s_nxt.dq_out = cyc.data;
        s_nxt.dq_oe  = cyc.rd ? '0 : DQ_ALL;
        if (i_byte_mode) begin
          s_nxt.dq_out[15] = cyc.ext[0];
          s_nxt.dq_oe      = s_nxt.dq_oe | DQ_15;
        end
        s_nxt.ph   = cyc.rd ? PH_RWAIT : PH_PULSE;
        s_nxt.oe_n = !cyc.rd;
        s_nxt.cnt  = cyc.rd ? RD_CYC : WP_CYC;
      end
      PH_PULSE: begin
        s_nxt.we_n = 1'b0;
        s_nxt.cnt  = s_r.cnt - CNT_ONE;
        if (s_r.cnt == CNT_ONE && !s_r.we_n) begin
          s_nxt.we_n = 1'b1;
          s_nxt.ph   = PH_HOLD;
          s_nxt.cnt  = WPH_CYC;
        end else if (s_r.we_n) begin
          s_nxt.cnt = s_r.cnt;
        end
      end
      PH_HOLD, PH_RWAIT: begin
        s_nxt.cnt = s_r.cnt - CNT_ONE;
        if (s_r.cnt == CNT_ONE) begin
          s_nxt.ce_n  = 1'b1;
          s_nxt.oe_n  = 1'b1;
          s_nxt.dq_oe = '0;
          if (s_r.ph == PH_RWAIT) begin
            s_nxt.rdata = rd_val;
            if (s_r.op == OP_QCHECK) begin
              s_nxt.mismatch = (rd_val != exp_word);  // see [R11] [R12] [R13] [R14]
            end  // see [R15] [R16] [R17] [R18] [R19] [R20] [R21] [R22]
          end
          if (s_r.last) begin
            s_nxt.ph    = PH_IDLE;
            s_nxt.done  = 1'b1;
            s_nxt.ready = 1'b1;
            s_nxt.mode  = mode_after(s_r.op, s_r.mode);
          end else begin
            s_nxt.step = s_r.step + STEP_ONE;
            s_nxt.ph   = PH_ISSUE;
          end
        end
      end
      default: s_nxt.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r       <= '0;
      s_r.ph    <= PH_IDLE;
      s_r.mode  <= M_ARRAY;  // see [R23]
      s_r.op    <= OP_READ;
      s_r.ce_n  <= 1'b1;
      s_r.oe_n  <= 1'b1;
      s_r.we_n  <= 1'b1;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ready    = s_r.ready;
  assign o_done     = s_r.done;
  assign o_err      = s_r.err;
  assign o_mismatch = s_r.mismatch;
  assign o_rdata    = s_r.rdata;
  assign o_mode     = s_r.mode;
  assign o_addr     = s_r.addr;
  assign o_dq_out   = s_r.dq_out;
  assign o_dq_oe    = s_r.dq_oe;
  assign o_ce_n     = s_r.ce_n;
  assign o_oe_n     = s_r.oe_n;
  assign o_we_n     = s_r.we_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sec_enter_a: assert property ((s_r.ph == PH_RWAIT || s_r.ph == PH_HOLD) && s_r.last &&
    s_r.cnt == CNT_ONE && s_r.op == OP_SEC_ENTER |=> o_mode == M_SECURE && o_done)  // see [R01]
    else $error("secure entry did not reach secure mode");
  sec_exit_a: assert property (o_done && !o_err && s_r.op == OP_SEC_EXIT
    |-> o_mode == M_ARRAY && $past(s_r.step) == 3'd3)  // see [R02]
    else $error("secure exit wrong mode or cycle count");
  sec_hold_a: assert property (o_mode == M_SECURE && !(s_nxt.done && s_r.op == OP_SEC_EXIT)
    |=> o_mode == M_SECURE)  // see [R05]
    else $error("secure mode left without exit");
  qry_cmd_a: assert property (!o_we_n && s_r.op == OP_QUERY
    |-> o_dq_out[7:0] == D_QRY[7:0] && (i_byte_mode ? {o_addr, o_dq_out[15]} == QRY_B :
    o_addr == QRY_W[22:0]))  // see [R06]
    else $error("query command at wrong address");
  qry_addr_a: assert property (!o_oe_n && !i_byte_mode &&
    (o_mode == M_QRY_ARR || o_mode == M_QRY_ID) |-> o_addr[22:7] == '0)  // see [R07]
    else $error("query read with high address bits set");
  qry_rst_a: assert property (o_mode == M_QRY_ID && s_r.op == OP_RESET && s_nxt.done
    |=> o_mode == M_IDENT)  // see [R10]
    else $error("reset from identification query lost mode");
  qry_arr_a: assert property (o_mode == M_QRY_ARR && s_r.op == OP_RESET && s_nxt.done
    |=> o_mode == M_ARRAY)  // see [R08]
    else $error("reset from query did not return to array");
  byte_lo_a: assert property (i_byte_mode && $rose(o_done) && s_r.op == OP_QCHECK
    |-> o_rdata[15:8] == 8'h00 && !o_dq_out[15])  // see [R24]
    else $error("byte-mode query word not on low byte");
  pins_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe[7:0] == 8'hFF)  // see [R03]
    else $error("write strobe without chip enable or with output enable");

  sec_cov: cover property (o_done && o_mode == M_SECURE);
  qid_cov: cover property (o_done && o_mode == M_QRY_ID);
  chk_cov: cover property (o_done && s_r.op == OP_QCHECK && !o_mismatch);
  ref_cov: cover property (o_err);

endmodule // fq_host

//--- rtl/fq_pkg.sv
package fq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus timing, ns and derived cycles at the reference clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_WP_NS       = 35;  // least write-enable low time
  localparam int T_WPH_NS      = 20;  // least hold after write-enable rise
  localparam int T_ACC_NS      = 70;  // longest read access
  localparam int SYNC_STAGES   = 2;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [3:0] WP_CYC   = 4'(ns2cyc(T_WP_NS));
  localparam logic [3:0] WPH_CYC  = 4'(ns2cyc(T_WPH_NS));
  localparam logic [3:0] RD_CYC   = 4'(ns2cyc(T_ACC_NS) + SYNC_STAGES + 1);
  localparam logic [3:0] CNT_ONE  = 4'h1;
  localparam logic [2:0] STEP_ONE = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // command addresses and codes
  localparam logic [23:0] UNL1_W  = 24'h00_0555;
  localparam logic [23:0] UNL2_W  = 24'h00_02AA;
  localparam logic [23:0] UNL1_B  = 24'h00_0AAA;
  localparam logic [23:0] UNL2_B  = 24'h00_0555;
  localparam logic [23:0] QRY_W   = 24'h00_0055;
  localparam logic [23:0] QRY_B   = 24'h00_00AA;
  localparam logic [23:0] ZERO_A  = 24'h00_0000;
  localparam logic [15:0] D_UNL1  = 16'h00AA;
  localparam logic [15:0] D_UNL2  = 16'h0055;
  localparam logic [15:0] D_SEC   = 16'h0088;
  localparam logic [15:0] D_ID    = 16'h0090;
  localparam logic [15:0] D_EXIT0 = 16'h0000;
  localparam logic [15:0] D_QRY   = 16'h0098;
  localparam logic [15:0] D_RST   = 16'h00F0;
  localparam int          QA_MSB  = 22;     // word-mode query: bits 22..7 zero
  localparam int          QA_LSB  = 7;
  localparam logic [15:0] HI_BYTE = 16'hFF00;
  localparam logic [15:0] DQ_ALL  = 16'hFFFF;
  localparam logic [15:0] DQ_15   = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // expected query words, word addresses 10h..3Ch
  localparam logic [5:0] QT_BASE = 6'h10;
  localparam logic [5:0] QT_LAST = 6'h3C;
  localparam int         QT_N    = 45;
  localparam logic [15:0] QT [QT_N] = '{
    16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
    16'h0000, 16'h0003, 16'h0004, 16'h0009, 16'h0000, 16'h0005, 16'h0005,
    16'h0004, 16'h0000, 16'h0018, 16'h0002, 16'h0000, 16'h0006, 16'h0000,
    16'h0001, 16'h007F, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [7:0] {
    OP_READ = 8'b0000_0001, OP_WRITE = 8'b0000_0010, OP_SEC_ENTER = 8'b0000_0100,
    OP_SEC_EXIT = 8'b0000_1000, OP_AUTOSEL = 8'b0001_0000, OP_QUERY = 8'b0010_0000,
    OP_RESET = 8'b0100_0000, OP_QCHECK = 8'b1000_0000
  } fq_op_t;

  typedef enum logic [4:0] {
    M_ARRAY = 5'b00001, M_SECURE = 5'b00010, M_IDENT = 5'b00100,
    M_QRY_ARR = 5'b01000, M_QRY_ID = 5'b10000
  } fq_mode_t;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001, PH_ISSUE = 5'b00010, PH_PULSE = 5'b00100,
    PH_HOLD = 5'b01000, PH_RWAIT = 5'b10000
  } fq_phase_t;

  typedef struct packed {
    fq_op_t      op;
    logic [23:0] addr;   // word address, or byte address in byte mode except query checks, which take a word index
    logic [15:0] data;
  } fq_req_t;

  typedef struct packed {
    logic        last;
    logic        rd;
    logic [23:0] ext;
    logic [15:0] data;
  } fq_cyc_t;

  typedef struct packed {
    fq_phase_t   ph;
    fq_mode_t    mode;
    fq_op_t      op;
    logic [2:0]  step;
    logic [23:0] uaddr;
    logic [15:0] udata;
    logic [3:0]  cnt;
    logic        rd;
    logic        last;
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        ready;
    logic        done;
    logic        err;
    logic        mismatch;
    logic [15:0] rdata;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
  } fq_state_t;

endpackage

//--- rtl/fq_rom.sv
`timescale 1ns/1ps
module fq_rom
  import fq_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic [5:0]  i_widx,
  output logic      [15:0] o_word
);
  // registered read keeps the comparator path short
  always_ff @(posedge i_ref_clk) begin
    if (i_widx >= QT_BASE && i_widx <= QT_LAST) begin
      o_word <= QT[6'(i_widx - QT_BASE)];
    end else begin
      o_word <= '0;
    end
  end
endmodule // fq_rom

//--- sim/fq_flash_model.sv
`timescale 1ns/1ps
module fq_flash_model
  import fq_pkg::*;
#(
  parameter logic [15:0] ID_WORD = 16'h1234,  // arbitrary identification word
  parameter logic [15:0] ARR_XOR = 16'h5A5A
)(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_byte_mode,
  input  wire logic        i_corrupt,
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_dq_host,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [15:0] o_dq
);
  fq_mode_t    mode_r;
  logic [1:0]  step_r;
  logic [15:0] sec_r [128];
  logic [15:0] last_r, word, rd_val, d;
  logic [23:0] ca, wa;
  logic        drive, qry;

  ////////////////////////////////////////////////////////////////////////////
  assign ca    = i_byte_mode ? {i_addr, i_dq_host[15]} : {1'b0, i_addr};
  assign wa    = {1'b0, i_addr};
  assign d     = i_byte_mode ? {8'h00, i_dq_host[7:0]} : i_dq_host;
  assign drive = !i_ce_n && !i_oe_n;
  assign qry   = (mode_r == M_QRY_ARR) || (mode_r == M_QRY_ID);

  // factory part preset; survives hardware reset like the real cells
  initial for (int i = 0; i < 128; i++) sec_r[i] = 16'hC000 | 16'(i);

  always @(posedge i_we_n or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= M_ARRAY;
      step_r <= 2'h0;
    end else if (!i_ce_n) begin
      step_r <= 2'h0;
      if (d == D_RST && mode_r != M_SECURE) begin
        mode_r <= (mode_r == M_QRY_ID) ? M_IDENT : M_ARRAY;
      end else if (d == D_QRY && ca == (i_byte_mode ? QRY_B : QRY_W) &&
                   (mode_r == M_ARRAY || mode_r == M_IDENT)) begin
        mode_r <= (mode_r == M_ARRAY) ? M_QRY_ARR : M_QRY_ID;
      end else if (step_r == 2'h0 && ca == (i_byte_mode ? UNL1_B : UNL1_W) && d == D_UNL1) begin
        step_r <= 2'h1;
      end else if (step_r == 2'h1 && ca == (i_byte_mode ? UNL2_B : UNL2_W) && d == D_UNL2) begin
        step_r <= 2'h2;
      end else if (step_r == 2'h2 && d == D_SEC) begin
        mode_r <= M_SECURE;
      end else if (step_r == 2'h2 && d == D_ID) begin
        if (mode_r == M_SECURE) step_r <= 2'h3;
        else mode_r <= M_IDENT;
      end else if (step_r == 2'h3 && d == D_EXIT0 && ca == ZERO_A) begin
        mode_r <= M_ARRAY;
      end else if (mode_r == M_SECURE && wa >= 24'h8 && wa < 24'h80) begin
        sec_r[wa[6:0]] <= d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (qry) begin
      if (!i_byte_mode && i_addr[22:7] != 16'h0000) word = 16'hFFFF;
      else if (wa >= 24'h10 && wa <= 24'h3C)
        word = QT[wa[5:0] - QT_BASE] ^ {15'h0000, i_corrupt};
      else word = 16'h0000;
    end else if (mode_r == M_SECURE && wa < 24'h80) word = sec_r[wa[6:0]];
    else if (mode_r == M_IDENT) word = ID_WORD;
    else word = wa[15:0] ^ ARR_XOR;
    // upper lanes float in byte mode, so show a changing pattern there
    rd_val = i_byte_mode ? {~last_r[15:8], word[7:0]} : word;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) last_r <= 16'h0F0F;
    else if (drive) last_r <= rd_val;
  end
  assign o_dq = drive ? rd_val : ~last_r;
endmodule // fq_flash_model

//--- sim/flash_query_and_secure_region_modes_tb_top.sv
`timescale 1ns/1ps
module flash_query_and_secure_region_modes_tb_top
  import fq_pkg::*;
;
  localparam logic [15:0] ID_W = 16'h1234;
  localparam logic [15:0] AX   = 16'h5A5A;
  logic        clk = 1'b0, rst = 1'b1, bm = 1'b0, valid = 1'b0, corrupt = 1'b0;
  fq_req_t     req = '0;
  logic        ready, done, err, mism, ce_n, oe_n, we_n;
  logic [15:0] rdata, dq_out, dq_oe, mdl_dq, dq_in;
  logic [22:0] addr;
  fq_mode_t    mode;
  int          err_count = 0, check_count = 0;

  always #25 clk = ~clk;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & mdl_dq);

  fq_host fq_host_inst (.i_ref_clk(clk), .i_rst(rst), .i_byte_mode(bm), .i_req_valid(valid),
    .i_req(req), .o_ready(ready), .o_done(done), .o_err(err), .o_mismatch(mism),
    .o_rdata(rdata), .o_mode(mode), .o_addr(addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
    .i_dq_in(dq_in), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n));
  fq_flash_model #(.ID_WORD(ID_W), .ARR_XOR(AX)) fq_flash_model_inst (.i_ref_clk(clk),
    .i_rst(rst), .i_byte_mode(bm), .i_corrupt(corrupt), .i_addr(addr), .i_dq_host(dq_out),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(mdl_dq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin err_count++; $display("BAD %0t word %h exp %h", $time, got, exp); end
  endtask
  task automatic chk_m(input fq_mode_t got, input fq_mode_t exp);
    check_count++;
    if (got !== exp) begin err_count++; $display("BAD %0t mode %b exp %b", $time, got, exp); end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin err_count++; $display("BAD %0t flag %b exp %b", $time, got, exp); end
  endtask
  // caller enters only while idle, so the request driven at the next edge is taken at the edge after it
  task automatic op(input fq_op_t o, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk) begin valid <= 1'b1; req <= '{o, a, d}; end
    @(posedge clk) valid <= 1'b0;
    // a refused query answers at the take edge itself
    #1;
    while (done !== 1'b1 && n < 40) begin @(posedge clk); #1; n++; end
    if (n >= 40) begin err_count++; $display("BAD %0t no done", $time); end
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    op(OP_READ, a, 16'h0000);
    chk_w(rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_query_arr();
    logic [15:0] lit [6] = '{16'h0051, 16'h0059, 16'h0027, 16'h0003, 16'h0018, 16'h007F};
    logic [23:0] at [6]  = '{24'h10, 24'h12, 24'h1B, 24'h1F, 24'h27, 24'h2D};
    op(OP_QUERY, QRY_W, D_QRY);
    chk_m(mode, M_QRY_ARR);
    for (int i = 16; i <= 60; i++) begin
      op(OP_QCHECK, 24'(i), 16'h0000);
      chk_b(mism, 1'b0);
    end
    for (int i = 0; i < 6; i++) rd(at[i], lit[i]);
    rd(24'h40_0010, 16'h0051);
    @(posedge clk) corrupt <= 1'b1;
    op(OP_QCHECK, 24'h13, 16'h0000);
    chk_b(mism, 1'b1);
    @(posedge clk) corrupt <= 1'b0;
    op(OP_RESET, ZERO_A, D_RST);
    chk_m(mode, M_ARRAY);
    rd(24'h10, 16'h0010 ^ AX);
  endtask

  task automatic t_query_id();
    op(OP_AUTOSEL, UNL1_W, D_ID);
    rd(24'h1, ID_W);
    op(OP_QUERY, QRY_W, D_QRY);
    chk_m(mode, M_QRY_ID);
    op(OP_QCHECK, 24'h2C, 16'h0000);
    chk_b(mism, 1'b0);
    op(OP_RESET, ZERO_A, D_RST);
    chk_m(mode, M_IDENT);
    rd(24'h1, ID_W);
    op(OP_RESET, ZERO_A, D_RST);
    chk_m(mode, M_ARRAY);
  endtask

  task automatic t_secure();
    op(OP_SEC_ENTER, UNL1_W, D_SEC);
    chk_m(mode, M_SECURE);
    rd(24'h3, 16'hC003);
    op(OP_WRITE, 24'h8, 16'h1357);
    rd(24'h8, 16'h1357);
    rd(24'h1_0000, 16'h0000 ^ AX);
    op(OP_RESET, ZERO_A, D_RST);
    chk_m(mode, M_SECURE);
    op(OP_QUERY, QRY_W, D_QRY);
    chk_b(err, 1'b1);
    op(OP_SEC_EXIT, UNL1_W, D_EXIT0);
    chk_m(mode, M_ARRAY);
    rd(24'h3, 16'h0003 ^ AX);
  endtask

  task automatic t_byte();
    @(posedge clk) bm <= 1'b1;
    op(OP_QUERY, QRY_B, D_QRY);
    chk_m(mode, M_QRY_ARR);
    for (int i = 16; i <= 28; i++) begin
      op(OP_QCHECK, 24'(i), 16'h0000);
      chk_b(mism, 1'b0);
    end
    rd(24'h20, 16'h0051);
    rd(24'h36, 16'h0027);
    op(OP_RESET, ZERO_A, D_RST);
    chk_m(mode, M_ARRAY);
    // byte-mode unlock addresses, secure data on the low lane
    op(OP_SEC_ENTER, UNL1_B, D_SEC);
    chk_m(mode, M_SECURE);
    rd(24'h6, 16'h0003);
    op(OP_SEC_EXIT, UNL1_B, D_EXIT0);
    chk_m(mode, M_ARRAY);
    @(posedge clk) bm <= 1'b0;
  endtask

  task automatic t_hw_reset();
    op(OP_SEC_ENTER, UNL1_W, D_SEC);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk_m(mode, M_ARRAY);
    chk_b(ce_n, 1'b1);
    chk_b(ready, 1'b1);
    rd(24'h3, 16'h0003 ^ AX);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk_m(mode, M_ARRAY);
    t_query_arr();
    t_query_id();
    t_secure();
    t_byte();
    t_hw_reset();
    close_out();
  end
  initial begin
    #2_000_000;
    err_count++;
    close_out();
  end
endmodule // flash_query_and_secure_region_modes_tb_top
